// *** common/mac_cfg_pkg.sv ***
// package for the mac pause, management and statistics configuration block
// assumes a single 40 MHz system clock and a plain strobe register port
`default_nettype none
package mac_cfg_pkg;
  localparam int ADDR_W = 12; // register port address width
  localparam int DATA_W = 32; // register data width
  // register byte addresses
  localparam logic [11:0] ADDR_MGMT_CTRL = 12'h014; // management busy and write-select
  localparam logic [11:0] ADDR_MGMT_DATA = 12'h018; // management data word
  localparam logic [11:0] ADDR_FLOW_CTRL = 12'h01c; // pause flow control
  localparam logic [11:0] ADDR_STAT_CTRL = 12'h100; // frame statistics control
  localparam logic [11:0] ADDR_RSV_FIRST = 12'h10c; // first reserved control word
  localparam logic [11:0] ADDR_RSV_SECOND = 12'h110; // second reserved control word
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h120; // sticky event status
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h124; // event mask
  localparam logic [11:0] ADDR_LONG_COUNT = 12'h128; // long frame counter
  // field positions
  localparam int MGMT_BUSY_BIT = 0; // management busy flag
  localparam int MGMT_WRITE_BIT = 1; // management write-select
  localparam int PAUSE_SEND_BIT = 0; // pause-send busy
  localparam int PAUSE_HONOUR_BIT = 1; // pause-honour enable
  localparam int QUANTA_LSB = 16; // pause quanta low bit
  localparam int QUANTA_W = 16; // pause quanta width
  localparam int MGMT_DATA_W = 16; // management data width
  localparam int LIMIT_LSB = 3; // long frame limit low bit
  localparam int LIMIT_W = 11; // long frame limit width
  localparam int STAT_RSV_BIT = 1; // statistics reserved bit
  // reset values
  localparam logic [31:0] FLOW_CTRL_RESET = 32'h0050_0002;
  localparam logic [31:0] STAT_CTRL_RESET = 32'h0000_2f72;
  localparam logic [31:0] MGMT_CTRL_RESET = 32'h0000_0000;
  // interrupt event bits
  localparam int EV_MGMT_DONE = 0; // management instruction finished
  localparam int EV_PAUSE_SENT = 1; // pause frame transmitted
  localparam int EV_LONG_FRAME = 2; // long frame counted
  localparam int EV_W = 3; // number of events
  // pause machine states
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00, // nothing pending
    PS_REQ = 2'b01, // asking the transmitter for a pause frame
    PS_SEND = 2'b10 // pause frame on the wire
  } pause_state_t;
endpackage : mac_cfg_pkg
`default_nettype wire

// *** design/hold_timer.sv ***
// down-counter of pause slot times for the receive-pause hold-off
// assumes slot_tick_i is a one-cycle enable at the slot rate
`default_nettype none
module hold_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic [CNT_W-1:0] value_i,
  input wire logic slot_tick_i,
  // state
  output logic active_o
);
  logic [CNT_W-1:0] remaining; // slots still to hold off

  // a fresh load restarts the count, as a new pause frame replaces the old time
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      remaining <= '0;
    end else if (load_i) begin
      remaining <= value_i;
    end else if (slot_tick_i && remaining != '0) begin
      remaining <= remaining - 1'b1;
    end
  end

  assign active_o = (remaining != '0);
endmodule : hold_timer
`default_nettype wire

// *** design/mac_pause_mgmt_config.sv ***
// configuration and control of a 10/100 mac: management data, pause frames, long frame limit
// assumes one 40 MHz clock, a strobe register port and a transmitter that handshakes pause frames
`default_nettype none
module mac_pause_mgmt_config
  import mac_cfg_pkg::*;
#(
  parameter int SLOT_DIV = 20 // system cycles per pause slot tick
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // register port
  input wire logic [mac_cfg_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [mac_cfg_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [mac_cfg_pkg::DATA_W-1:0] reg_rdata_o,
  // management engine
  output logic mgmt_start_o,
  output logic mgmt_write_o,
  output logic [mac_cfg_pkg::MGMT_DATA_W-1:0] mgmt_wdata_o,
  input wire logic mgmt_done_i,
  input wire logic [mac_cfg_pkg::MGMT_DATA_W-1:0] mgmt_rdata_i,
  // transmit pause frames
  output logic pause_req_o,
  output logic [mac_cfg_pkg::QUANTA_W-1:0] pause_quanta_o,
  input wire logic pause_ack_i,
  input wire logic pause_done_i,
  // received pause frames
  input wire logic rx_pause_i,
  input wire logic [mac_cfg_pkg::QUANTA_W-1:0] rx_pause_quanta_i,
  output logic tx_hold_o,
  // transmitted frame lengths
  input wire logic tx_frame_end_i,
  input wire logic [mac_cfg_pkg::LIMIT_W-1:0] tx_frame_len_i,
  output logic long_frame_o,
  // interrupt
  output logic irq_o
);
  import mac_cfg_pkg::*;

  // register state
  logic [DATA_W-1:0] flow_ctrl; // quanta and honour enable; the send bit is stored as zero
  logic [DATA_W-1:0] stat_ctrl; // long frame limit and reserved bits
  logic [DATA_W-1:0] rsv_first; // plain storage word
  logic [DATA_W-1:0] rsv_second; // plain storage word
  logic [MGMT_DATA_W-1:0] mgmt_data; // management data field
  logic mgmt_busy; // management busy flag
  logic mgmt_write; // management write-select
  logic [EV_W-1:0] irq_status; // sticky events
  logic [EV_W-1:0] irq_mask; // event enables
  logic [DATA_W-1:0] long_count; // long frames seen
  pause_state_t pause_state; // pause send machine
  pause_state_t next_pause_state;
  logic [$clog2(SLOT_DIV)-1:0] slot_div; // slot rate divider
  logic slot_tick; // one-cycle slot enable
  logic [EV_W-1:0] events; // this cycle's events

  // write decode, one term per register
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction : hit

  logic wr_flow, wr_stat, wr_mgmt_ctrl, wr_mgmt_data;
  assign wr_flow = reg_wr_i && hit(reg_addr_i, ADDR_FLOW_CTRL);
  assign wr_stat = reg_wr_i && hit(reg_addr_i, ADDR_STAT_CTRL);
  assign wr_mgmt_ctrl = reg_wr_i && hit(reg_addr_i, ADDR_MGMT_CTRL);
  assign wr_mgmt_data = reg_wr_i && hit(reg_addr_i, ADDR_MGMT_DATA);

  // pause quanta and honour enable; the send bit is owned by the pause machine
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flow_ctrl <= FLOW_CTRL_RESET;
    end else if (wr_flow) begin
      flow_ctrl <= {reg_wdata_i[DATA_W-1:PAUSE_SEND_BIT+1], 1'b0};
    end
  end

  // statistics control and reserved words: plain storage, reserved bits keep what software wrote
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stat_ctrl <= STAT_CTRL_RESET;
      rsv_first <= '0;
      rsv_second <= '0;
    end else begin
      if (wr_stat) begin
        stat_ctrl <= reg_wdata_i;
      end
      if (reg_wr_i && hit(reg_addr_i, ADDR_RSV_FIRST)) begin
        rsv_first <= reg_wdata_i;
      end
      if (reg_wr_i && hit(reg_addr_i, ADDR_RSV_SECOND)) begin
        rsv_second <= reg_wdata_i;
      end
    end
  end

  // pause send machine: request, wait for the transmitter to take it, wait for the end
  always_comb begin
    next_pause_state = pause_state;
    case (pause_state)
      PS_IDLE: begin
        // a write of one starts a frame; while busy a second write starts no frame but still loads quanta and honour enable
        if (wr_flow && reg_wdata_i[PAUSE_SEND_BIT]) begin
          next_pause_state = PS_REQ;
        end
      end
      PS_REQ: begin
        if (pause_ack_i) begin
          next_pause_state = PS_SEND;
        end
      end
      PS_SEND: begin
        if (pause_done_i) begin
          next_pause_state = PS_IDLE;
        end
      end
      default: next_pause_state = PS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pause_state <= PS_IDLE;
    end else begin
      pause_state <= next_pause_state;
    end
  end

  assign pause_req_o = (pause_state == PS_REQ);
  assign pause_quanta_o = flow_ctrl[QUANTA_LSB +: QUANTA_W];

  // management control: busy set by software start, cleared by the engine's done
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mgmt_busy <= MGMT_CTRL_RESET[MGMT_BUSY_BIT];
      mgmt_write <= MGMT_CTRL_RESET[MGMT_WRITE_BIT];
    end else if (wr_mgmt_ctrl && !mgmt_busy) begin
      mgmt_write <= reg_wdata_i[MGMT_WRITE_BIT];
      mgmt_busy <= reg_wdata_i[MGMT_BUSY_BIT];
    end else if (mgmt_busy && mgmt_done_i) begin
      mgmt_busy <= 1'b0;
    end
  end

  // start pulse the cycle the instruction is accepted
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mgmt_start_o <= 1'b0;
    end else begin
      mgmt_start_o <= wr_mgmt_ctrl && !mgmt_busy && reg_wdata_i[MGMT_BUSY_BIT];
    end
  end
  assign mgmt_write_o = mgmt_write;
  assign mgmt_wdata_o = mgmt_data;

  // data field: software writes it, a finished read overwrites it with the phy's word
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mgmt_data <= '0;
    end else if (mgmt_busy && mgmt_done_i && !mgmt_write) begin
      mgmt_data <= mgmt_rdata_i;
    end else if (wr_mgmt_data && !mgmt_busy) begin
      mgmt_data <= reg_wdata_i[MGMT_DATA_W-1:0];
    end
  end

  // slot tick divider; a slot is modelled as SLOT_DIV system cycles
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      slot_div <= '0;
    end else if (slot_div == $clog2(SLOT_DIV)'(SLOT_DIV - 1)) begin
      slot_div <= '0;
    end else begin
      slot_div <= slot_div + 1'b1;
    end
  end
  assign slot_tick = (slot_div == $clog2(SLOT_DIV)'(SLOT_DIV - 1));

  // received pause: loaded only while honouring is enabled
  hold_timer #(
    .CNT_W(QUANTA_W)
  ) u_hold (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .load_i(rx_pause_i && flow_ctrl[PAUSE_HONOUR_BIT]),
    .value_i(rx_pause_quanta_i),
    .slot_tick_i(slot_tick),
    .active_o(tx_hold_o)
  );

  // long frame detection and count
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      long_frame_o <= 1'b0;
      long_count <= '0;
    end else begin
      long_frame_o <= tx_frame_end_i && (tx_frame_len_i > stat_ctrl[LIMIT_LSB +: LIMIT_W]);
      if (tx_frame_end_i && (tx_frame_len_i > stat_ctrl[LIMIT_LSB +: LIMIT_W])) begin
        long_count <= long_count + 1'b1;
      end
    end
  end

  // events and sticky status; a new event wins over a write-one clear
  always_comb begin
    events = '0;
    events[EV_MGMT_DONE] = mgmt_busy && mgmt_done_i;
    events[EV_PAUSE_SENT] = (pause_state == PS_SEND) && pause_done_i;
    events[EV_LONG_FRAME] = long_frame_o;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      if (reg_wr_i && hit(reg_addr_i, ADDR_IRQ_STATUS)) begin
        irq_status <= (irq_status & ~reg_wdata_i[EV_W-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
      if (reg_wr_i && hit(reg_addr_i, ADDR_IRQ_MASK)) begin
        irq_mask <= reg_wdata_i[EV_W-1:0];
      end
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  // read mux, registered; unmapped addresses read zero
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_MGMT_CTRL: reg_rdata_o <= {30'h0, mgmt_write, mgmt_busy};
        ADDR_MGMT_DATA: reg_rdata_o <= {16'h0, mgmt_data};
        ADDR_FLOW_CTRL: reg_rdata_o <= {flow_ctrl[DATA_W-1:1], pause_state != PS_IDLE};
        ADDR_STAT_CTRL: reg_rdata_o <= stat_ctrl;
        ADDR_RSV_FIRST: reg_rdata_o <= rsv_first;
        ADDR_RSV_SECOND: reg_rdata_o <= rsv_second;
        ADDR_IRQ_STATUS: reg_rdata_o <= {29'h0, irq_status};
        ADDR_IRQ_MASK: reg_rdata_o <= {29'h0, irq_mask};
        ADDR_LONG_COUNT: reg_rdata_o <= long_count;
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end
endmodule : mac_pause_mgmt_config
`default_nettype wire

// *** sim/mac_cfg_props.sv ***
// port checker for the mac configuration block
// assumes it is bound onto every instance of the top design module
`default_nettype none
module mac_cfg_props
  import mac_cfg_pkg::*;
#(
  parameter int SLOT_DIV = 20 // kept in step with the design
) (
  // watched ports
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [mac_cfg_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [mac_cfg_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [mac_cfg_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic mgmt_start_o,
  input wire logic mgmt_write_o,
  input wire logic pause_req_o,
  input wire logic [mac_cfg_pkg::QUANTA_W-1:0] pause_quanta_o,
  input wire logic pause_ack_i,
  input wire logic rx_pause_i,
  input wire logic tx_hold_o,
  input wire logic tx_frame_end_i,
  input wire logic long_frame_o
);
  // one domain, so one clock and one disable for all
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  property p_mgmt_cause; mgmt_start_o |-> $past(reg_wr_i) && $past(reg_addr_i) == ADDR_MGMT_CTRL; endproperty
  a_mgmt_cause: assert property (p_mgmt_cause) else $error("management start without a start write");
  property p_mgmt_dir; mgmt_start_o |-> mgmt_write_o == $past(reg_wdata_i[MGMT_WRITE_BIT]); endproperty
  a_mgmt_dir: assert property (p_mgmt_dir) else $error("management direction wrong");
  property p_pause_cause; $rose(pause_req_o) |-> $past(reg_wr_i) && $past(reg_wdata_i[PAUSE_SEND_BIT]); endproperty
  a_pause_cause: assert property (p_pause_cause) else $error("pause request without a send write");
  property p_quanta; $rose(pause_req_o) |-> pause_quanta_o == $past(reg_wdata_i[31:16]); endproperty
  a_quanta: assert property (p_quanta) else $error("pause quanta not the written value");
  property p_pause_hold; pause_req_o && !pause_ack_i |=> pause_req_o; endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause request dropped early");
  property p_pause_drop; pause_req_o && pause_ack_i |=> !pause_req_o; endproperty
  a_pause_drop: assert property (p_pause_drop) else $error("pause request kept after ack");
  property p_long_cause; long_frame_o |-> $past(tx_frame_end_i); endproperty
  a_long_cause: assert property (p_long_cause) else $error("long frame flag without frame end");
  property p_hold_cause; $rose(tx_hold_o) |-> $past(rx_pause_i); endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("hold-off without received pause");
endmodule : mac_cfg_props
bind mac_pause_mgmt_config mac_cfg_props #(.SLOT_DIV(SLOT_DIV)) u_mac_cfg_props (.clk_sys_i, .rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mgmt_start_o, .mgmt_write_o, .pause_req_o, .pause_quanta_o,
  .pause_ack_i, .rx_pause_i, .tx_hold_o, .tx_frame_end_i, .long_frame_o);
`default_nettype wire

// *** sim/mac_far_model.sv ***
// model of the management engine and the pause-frame transmitter
// assumes one-cycle start pulses and a request held until ack
`default_nettype none
module mac_far_model #(
  parameter logic [15:0] RD_WORD = 16'h5aa5 // word the phy returns
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // requests and pace
  input wire logic mgmt_start_i,
  input wire logic pause_req_i,
  input wire logic slow_i,
  // answers
  output logic mgmt_done_o,
  output logic [15:0] mgmt_rdata_o,
  output logic pause_ack_o,
  output logic pause_done_o
);
  logic [3:0] m_cnt; // cycles left of the instruction
  logic [3:0] p_cnt; // cycles left of the pause frame
  // read word only valid with done, inverted otherwise so no stale match
  assign mgmt_rdata_o = mgmt_done_o ? RD_WORD : ~RD_WORD;
  // instruction and frame timers, slow pace to stretch busy
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      m_cnt <= 4'h0;
      p_cnt <= 4'h0;
      mgmt_done_o <= 1'b0;
      pause_ack_o <= 1'b0;
      pause_done_o <= 1'b0;
    end else begin
      mgmt_done_o <= (m_cnt == 4'h1);
      pause_done_o <= (p_cnt == 4'h1);
      pause_ack_o <= pause_req_i && !pause_ack_o && p_cnt == 4'h0;
      if (mgmt_start_i) m_cnt <= slow_i ? 4'hc : 4'h3;
      else if (m_cnt != 4'h0) m_cnt <= m_cnt - 4'h1;
      if (pause_ack_o) p_cnt <= slow_i ? 4'h9 : 4'h3;
      else if (p_cnt != 4'h0) p_cnt <= p_cnt - 4'h1;
    end
  end
endmodule : mac_far_model
`default_nettype wire

// *** sim/tb_mac_pause_mgmt_config.sv ***
// self-checking bench of the mac configuration block
// assumes the far-side model answers management and pause requests
`default_nettype none
module tb_mac_pause_mgmt_config;
  timeunit 1ns;
  timeprecision 1ps;
  import mac_cfg_pkg::*;
  localparam int SD = 2; // short slot so hold-off ends quickly
  localparam logic [15:0] RD_WORD = 16'h5aa5;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, slow = 1'b0;
  logic rx_pause_i = 1'b0, tx_frame_end_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rd_val;
  logic [15:0] rx_pause_quanta_i = 16'h0, mgmt_wdata_o, pause_quanta_o, mgmt_rdata_i;
  logic [10:0] tx_frame_len_i = 11'h000;
  logic mgmt_start_o, mgmt_write_o, mgmt_done_i, pause_req_o, pause_ack_i, pause_done_i;
  logic tx_hold_o, long_frame_o, irq_o;
  int err_total = 0, total_checks = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  mac_pause_mgmt_config #(.SLOT_DIV(SD)) u_mac_pause_mgmt_config (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mgmt_start_o, .mgmt_write_o, .mgmt_wdata_o, .mgmt_done_i, .mgmt_rdata_i,
    .pause_req_o, .pause_quanta_o, .pause_ack_i, .pause_done_i, .rx_pause_i, .rx_pause_quanta_i, .tx_hold_o,
    .tx_frame_end_i, .tx_frame_len_i, .long_frame_o, .irq_o);
  mac_far_model #(.RD_WORD(RD_WORD)) u_mac_far_model (.clk_sys_i, .rst_i, .mgmt_start_i(mgmt_start_o),
    .pause_req_i(pause_req_o), .slow_i(slow), .mgmt_done_o(mgmt_done_i), .mgmt_rdata_o(mgmt_rdata_i),
    .pause_ack_o(pause_ack_i), .pause_done_o(pause_done_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle write strobe; returns at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd
  // software polls busy low before the next request, bounded
  task automatic idle_wait(input logic [11:0] a, input int b);
    for (int i = 0; i < 40; i++) begin
      rd(a, rd_val);
      if (rd_val[b] === 1'b0) break;
    end
  endtask : idle_wait
  task automatic t_regs();
    rd(ADDR_FLOW_CTRL, rd_val); chk(rd_val, FLOW_CTRL_RESET);
    rd(ADDR_STAT_CTRL, rd_val); chk(rd_val, STAT_CTRL_RESET);
    rd(12'h0f0, rd_val); chk(rd_val, 32'h0);
    wr(ADDR_RSV_FIRST, 32'hffff_ffff); rd(ADDR_RSV_FIRST, rd_val); chk(rd_val, 32'hffff_ffff);
    wr(ADDR_RSV_SECOND, 32'hffff_ffff); rd(ADDR_RSV_SECOND, rd_val); chk(rd_val, 32'hffff_ffff);
    wr(ADDR_STAT_CTRL, 32'h0000_0322); rd(ADDR_STAT_CTRL, rd_val); chk(rd_val, 32'h0000_0322);
    $display("test regs done");
  endtask : t_regs
  task automatic t_mgmt();
    slow <= 1'b1;
    wr(ADDR_MGMT_DATA, 32'h0000_1234);
    wr(ADDR_MGMT_CTRL, 32'h0000_0003);
    #1 chk({mgmt_start_o, mgmt_write_o, mgmt_wdata_o}, {2'b11, 16'h1234});
    rd(ADDR_MGMT_CTRL, rd_val); chk(rd_val[0], 1'b1);
    idle_wait(ADDR_MGMT_CTRL, MGMT_BUSY_BIT); chk(rd_val[0], 1'b0);
    slow <= 1'b0;
    wr(ADDR_MGMT_CTRL, 32'h0000_0001);
    #1 chk({mgmt_start_o, mgmt_write_o}, 2'b10);
    idle_wait(ADDR_MGMT_CTRL, MGMT_BUSY_BIT);
    rd(ADDR_MGMT_DATA, rd_val); chk(rd_val, {16'h0, RD_WORD});
    $display("test mgmt done");
  endtask : t_mgmt
  task automatic t_pause();
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    slow <= 1'b1;
    wr(ADDR_FLOW_CTRL, 32'h1234_0003);
    #1 chk({pause_req_o, pause_quanta_o}, {1'b1, 16'h1234});
    rd(ADDR_FLOW_CTRL, rd_val); chk(rd_val[0], 1'b1);
    idle_wait(ADDR_FLOW_CTRL, PAUSE_SEND_BIT); chk(rd_val, 32'h1234_0002);
    chk(irq_o, 1'b1);
    wr(ADDR_IRQ_STATUS, 32'h0000_0002);
    #1 chk(irq_o, 1'b0);
    $display("test pause done");
  endtask : t_pause
  task automatic frame(input logic [10:0] len, input logic exp);
    @(posedge clk_sys_i);
    tx_frame_end_i <= 1'b1;
    tx_frame_len_i <= len;
    @(posedge clk_sys_i);
    tx_frame_end_i <= 1'b0;
    #1 chk(long_frame_o, exp);
  endtask : frame
  task automatic rx(input logic exp);
    @(posedge clk_sys_i);
    rx_pause_i <= 1'b1;
    rx_pause_quanta_i <= 16'h0003;
    @(posedge clk_sys_i);
    rx_pause_i <= 1'b0;
    #1 chk(tx_hold_o, exp);
  endtask : rx
  task automatic t_frames();
    frame(11'h065, 1'b1);
    frame(11'h064, 1'b0);
    rd(ADDR_LONG_COUNT, rd_val); chk(rd_val, 32'h1);
    rx(1'b1);
    repeat (3) @(posedge clk_sys_i);
    #1 chk(tx_hold_o, 1'b1);
    repeat (3 * SD + 4) @(posedge clk_sys_i);
    #1 chk(tx_hold_o, 1'b0);
    wr(ADDR_FLOW_CTRL, 32'h1234_0000);
    rx(1'b0);
    $display("test frames done");
  endtask : t_frames
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_regs();
    t_mgmt();
    t_pause();
    t_frames();
    give_verdict();
  end
  // watchdog well beyond the hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    give_verdict();
  end
endmodule : tb_mac_pause_mgmt_config
`default_nettype wire
